// ---- design/raw_vbi_pkg.sv ----
// constants and register map of the raw vbi capture window block
`default_nettype none
package raw_vbi_pkg;

  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL       = 6'h11;
  localparam logic [5:0] IDX_START      = 6'h12;
  localparam logic [5:0] IDX_END_LOW    = 6'h13;
  localparam logic [5:0] IDX_END_HIGH   = 6'h14;
  localparam logic [5:0] IDX_LINE_LOW   = 6'h15;
  localparam logic [5:0] IDX_LINE_MID   = 6'h16;
  localparam logic [5:0] IDX_LINE_TOP   = 6'h17;
  localparam logic [5:0] IDX_STATUS     = 6'h1F;

  // values after reset
  localparam logic [7:0] RST_START      = 8'h7A;
  localparam logic [7:0] RST_END_LOW    = 8'h4A;
  localparam logic [1:0] RST_END_HIGH   = 2'h3;
  localparam logic [7:0] RST_LINE_LOW   = 8'hFE;
  localparam logic [7:0] RST_LINE_MID   = 8'h1F;
  localparam logic [2:0] RST_LINE_TOP   = 3'h0;
  localparam logic [2:0] RST_CTRL       = 3'h0;

  // control field positions
  localparam int CTRL_ODD_BIT           = 0;
  localparam int CTRL_EVEN_BIT          = 1;
  localparam int CTRL_ALL_BIT           = 2;

  // status field positions
  localparam int STAT_WINDOW_BIT        = 0;
  localparam int STAT_LINE_BIT          = 1;
  localparam int STAT_GATE_BIT          = 2;

  // line mask geometry and first line per standard and field
  localparam logic [9:0] MASK_BITS      = 10'h013;
  localparam logic [9:0] NTSC_ODD_BASE  = 10'h009;
  localparam logic [9:0] NTSC_EVEN_BASE = 10'h110;
  localparam logic [9:0] PAL_ODD_BASE   = 10'h005;
  localparam logic [9:0] PAL_EVEN_BASE  = 10'h13E;

  // saturation value of the double-rate tick counter
  localparam logic [10:0] TICK_MAX      = 11'h7FF;

endpackage : raw_vbi_pkg
`default_nettype wire

// ---- design/raw_vbi_capture_window.sv ----
// raw vbi sampling window and line selection with wishbone registers
//
// Our own choice: register access over Wishbone.
`default_nettype none
module raw_vbi_capture_window
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // video timing
  input  wire logic        line_sync_i,
  input  wire logic        double_rate_tick_i,
  input  wire logic        field_even_i,
  input  wire logic        pal_mode_i,
  input  wire logic [9:0]  line_number_i,
  // capture datapath
  output logic             window_open_o,
  output logic             line_selected_o,
  output logic             capture_gate_o
);

  typedef struct packed {
    logic        sync_meta;
    logic        sync_stable;
    logic        sync_prev;
    logic        armed;
    logic [10:0] tick_cnt;
    logic [7:0]  start;
    logic [7:0]  end_low;
    logic [1:0]  end_high;
    logic [18:0] line_mask;
    logic [2:0]  ctrl;
    logic        window;
    logic        line_on;
    logic        gate;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // is the line inside the mask range and its bit set
  function automatic logic mask_hit(input logic [18:0] mask,
                                    input logic [9:0]  line,
                                    input logic [9:0]  base);
    logic [9:0] offset;
    offset = line - base;
    mask_hit = (line >= base) && (offset < raw_vbi_pkg::MASK_BITS)
               && mask[offset[4:0]];
  endfunction

  logic        line_edge;
  logic        req;
  logic        wr_commit;
  logic [5:0]  idx;
  logic        aligned;
  logic [9:0]  end_count;
  logic [10:0] open_ticks;
  logic [10:0] close_ticks;
  logic [9:0]  base;
  logic        field_on;

  assign line_edge   = state_reg.sync_stable & ~state_reg.sync_prev;
  assign req         = cyc_i & stb_i;
  // only the low byte lane carries register data
  assign wr_commit   = req & we_i & state_reg.ack & sel_i[0];
  assign idx         = adr_i[7:2];
  assign aligned     = (adr_i[1:0] == 2'h0);
  assign end_count   = {state_reg.end_high, state_reg.end_low};
  assign open_ticks  = {3'h0, state_reg.start} << 1;
  assign close_ticks = {end_count, 1'b0};

  always_comb
  begin
    state_next = state_reg;

    // line sync pin crosses two flops first
    state_next.sync_meta   = line_sync_i;
    state_next.sync_stable = state_reg.sync_meta;
    state_next.sync_prev   = state_reg.sync_stable;

    // double-rate periods since the leading edge of line sync
    // saturates, so a lost sync keeps the window shut
    if (line_edge)
    begin
      state_next.armed    = 1'b1;
      state_next.tick_cnt = 11'h000;
    end
    else if (double_rate_tick_i && state_reg.tick_cnt != raw_vbi_pkg::TICK_MAX)
    begin
      state_next.tick_cnt = state_reg.tick_cnt + 11'h001;
    end

    // open at start steps, close at stop steps
    state_next.window = state_reg.armed && !line_edge
                        && (state_reg.tick_cnt >= open_ticks)
                        && (state_reg.tick_cnt < close_ticks);

    // first masked line depends on standard and field
    if (pal_mode_i)
    begin
      base = field_even_i ? raw_vbi_pkg::PAL_EVEN_BASE
                          : raw_vbi_pkg::PAL_ODD_BASE;
    end
    else
    begin
      base = field_even_i ? raw_vbi_pkg::NTSC_EVEN_BASE
                          : raw_vbi_pkg::NTSC_ODD_BASE;
    end

    field_on = field_even_i ? state_reg.ctrl[raw_vbi_pkg::CTRL_EVEN_BIT]
                            : state_reg.ctrl[raw_vbi_pkg::CTRL_ODD_BIT];

    if (!field_on)
    begin
      state_next.line_on = 1'b0;
    end
    else if (state_reg.ctrl[raw_vbi_pkg::CTRL_ALL_BIT])
    begin
      state_next.line_on = 1'b1;
    end
    else
    begin
      state_next.line_on = mask_hit(state_reg.line_mask,
                                    line_number_i, base);
    end

    state_next.gate = state_reg.window & state_reg.line_on;

    // bus answer one cycle after the request is seen
    state_next.ack = req & ~state_reg.ack;

    // read data registered so it stands with ack
    state_next.rdata = 32'h0000_0000;
    if (aligned)
    begin
      unique case (idx)
        raw_vbi_pkg::IDX_CTRL:
          state_next.rdata[2:0] = state_reg.ctrl;
        raw_vbi_pkg::IDX_START:
          state_next.rdata[7:0] = state_reg.start;
        raw_vbi_pkg::IDX_END_LOW:
          state_next.rdata[7:0] = state_reg.end_low;
        raw_vbi_pkg::IDX_END_HIGH:
          state_next.rdata[1:0] = state_reg.end_high;
        raw_vbi_pkg::IDX_LINE_LOW:
          state_next.rdata[7:0] = state_reg.line_mask[7:0];
        raw_vbi_pkg::IDX_LINE_MID:
          state_next.rdata[7:0] = state_reg.line_mask[15:8];
        raw_vbi_pkg::IDX_LINE_TOP:
          state_next.rdata[2:0] = state_reg.line_mask[18:16];
        raw_vbi_pkg::IDX_STATUS:
        begin
          state_next.rdata[raw_vbi_pkg::STAT_WINDOW_BIT] = state_reg.window;
          state_next.rdata[raw_vbi_pkg::STAT_LINE_BIT]   = state_reg.line_on;
          state_next.rdata[raw_vbi_pkg::STAT_GATE_BIT]   = state_reg.gate;
        end
        default:
          state_next.rdata = 32'h0000_0000;
      endcase
    end

    // writes land on the edge where the master sees ack
    if (wr_commit && aligned)
    begin
      unique case (idx)
        raw_vbi_pkg::IDX_CTRL:
          state_next.ctrl = dat_i[2:0];
        raw_vbi_pkg::IDX_START:
          state_next.start = dat_i[7:0];
        raw_vbi_pkg::IDX_END_LOW:
          state_next.end_low = dat_i[7:0];
        raw_vbi_pkg::IDX_END_HIGH:
          state_next.end_high = dat_i[1:0];
        raw_vbi_pkg::IDX_LINE_LOW:
          state_next.line_mask[7:0] = dat_i[7:0];
        raw_vbi_pkg::IDX_LINE_MID:
          state_next.line_mask[15:8] = dat_i[7:0];
        raw_vbi_pkg::IDX_LINE_TOP:
          state_next.line_mask[18:16] = dat_i[2:0];
        default:
        begin
        end
      endcase
    end

    // registers back to reset values, outputs low
    if (rst_i)
    begin
      state_next           = '0;
      state_next.start     = raw_vbi_pkg::RST_START;
      state_next.end_low   = raw_vbi_pkg::RST_END_LOW;
      state_next.end_high  = raw_vbi_pkg::RST_END_HIGH;
      state_next.line_mask = {raw_vbi_pkg::RST_LINE_TOP,
                              raw_vbi_pkg::RST_LINE_MID,
                              raw_vbi_pkg::RST_LINE_LOW};
      state_next.ctrl      = raw_vbi_pkg::RST_CTRL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  assign dat_o           = state_reg.rdata;
  assign ack_o           = state_reg.ack;
  assign window_open_o   = state_reg.window;
  assign line_selected_o = state_reg.line_on;
  assign capture_gate_o  = state_reg.gate;

endmodule // raw_vbi_capture_window
`default_nettype wire

// ---- testbench/raw_vbi_capture_window_chk.sv ----
// port assertions for the raw vbi capture window
`default_nettype none
module raw_vbi_capture_window_chk
(
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // video side
  input wire logic        double_rate_tick_i,
  input wire logic        window_open_o,
  input wire logic        line_selected_o,
  input wire logic        capture_gate_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; $rose(cyc_i && stb_i); endsequence
  sequence s_both; window_open_o && line_selected_o; endsequence
  property p_ack_wait; s_req |=> ack_o; endproperty
  property p_ack_once; ack_o |=> !ack_o; endproperty
  property p_no_spur; !(cyc_i && stb_i) |=> !ack_o; endproperty
  property p_hi_zero; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  property p_unal;
    ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0;
  endproperty
  property p_gate_on; s_both |=> capture_gate_o; endproperty
  property p_gate_off; !window_open_o |=> !capture_gate_o; endproperty
  property p_win_tick;
    $rose(window_open_o) |-> $past(double_rate_tick_i, 2)
                             || $past(ack_o && we_i, 2);
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack late");
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  a_no_spur: assert property (p_no_spur) else $error("stray ack");
  a_hi_zero: assert property (p_hi_zero) else $error("high bits");
  a_unal: assert property (p_unal) else $error("unaligned data");
  a_gate_on: assert property (p_gate_on) else $error("gate off");
  a_gate_off: assert property (p_gate_off) else $error("gate on");
  a_win_tick: assert property (p_win_tick) else $error("no tick");
endmodule // raw_vbi_capture_window_chk
bind raw_vbi_capture_window raw_vbi_capture_window_chk i_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .double_rate_tick_i(double_rate_tick_i),
  .window_open_o(window_open_o), .line_selected_o(line_selected_o),
  .capture_gate_o(capture_gate_o)
);
`default_nettype wire

// ---- testbench/raw_vbi_capture_window_tb_top.sv ----
// self-checking bench for the raw vbi capture window
`default_nettype none
module raw_vbi_capture_window_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc, stb, we, sync, tick, run, ev, pal;
  logic        ack, win, lsel, gate;
  logic [7:0]  adr;
  logic [3:0]  sel, bsel;
  logic [9:0]  line;
  logic [31:0] dat, dq, q;
  int          n_errors, samples_checked;
  raw_vbi_capture_window i_raw_vbi_capture_window
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dq),
    .ack_o(ack), .line_sync_i(sync), .double_rate_tick_i(tick),
    .field_even_i(ev), .pal_mode_i(pal), .line_number_i(line),
    .window_open_o(win), .line_selected_o(lsel), .capture_gate_o(gate)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // one tick every second cycle while running
  always @(posedge clk_i) tick <= run & ~tick;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, bsel, 24'h0, d};
    for (k = 0; k < 40 && ack !== 1'b1; k++) @(posedge clk_i);
    q = dq;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'b1)
    begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, {24'h0, e});
  endtask
  task automatic ls(input logic [2:0] c, input logic p, e,
                    input logic [9:0] l, input logic x);
    wb(1'b1, 8'h44, {5'h0, c});
    {pal, ev, line} <= {p, e, l};
    repeat (3) @(posedge clk_i);
    chk("line_selected", {31'h0, lsel}, {31'h0, x});
  endtask
  task automatic wn(input logic [7:0] s, lo, hi, input int x);
    int n;
    int g;
    n = 0;
    g = 0;
    wb(1'b1, 8'h48, s);
    wb(1'b1, 8'h4C, lo);
    wb(1'b1, 8'h50, hi);
    {sync, run} <= 2'h3;
    repeat (4) @(posedge clk_i);
    sync <= 1'b0;
    repeat (1200)
    begin
      @(posedge clk_i);
      n += int'(win === 1'b1);
      g += int'(gate === 1'b1);
    end
    run <= 1'b0;
    chk("window_cycles", n, x);
    chk("gate_cycles", g, x);
  endtask
  initial
  begin
    {rst_i, cyc, stb, we, sync, run, ev, pal} = 8'h80;
    bsel = 4'h1;
    {adr, sel, dat, line} = {8'h00, 4'h1, 32'h0, 10'h000};
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h48, 8'h7A);
    rd(8'h4C, 8'h4A);
    rd(8'h50, 8'h03);
    rd(8'h54, 8'hFE);
    rd(8'h58, 8'h1F);
    rd(8'h5C, 8'h00);
    wb(1'b1, 8'h50, 8'hFF);
    rd(8'h50, 8'h03);
    wb(1'b1, 8'h5C, 8'hFF);
    rd(8'h5C, 8'h07);
    bsel = 4'h0;
    wb(1'b1, 8'h48, 8'h55);
    bsel = 4'h1;
    rd(8'h48, 8'h7A);
    rd(8'h60, 8'h00);
    rd(8'h49, 8'h00);
    wb(1'b1, 8'h54, 8'h01);
    wb(1'b1, 8'h58, 8'h00);
    wb(1'b1, 8'h5C, 8'h04);
    ls(3'h1, 1'b0, 1'b0, 10'h009, 1'b1);
    ls(3'h1, 1'b0, 1'b0, 10'h00A, 1'b0);
    ls(3'h1, 1'b0, 1'b0, 10'h01B, 1'b1);
    ls(3'h1, 1'b1, 1'b0, 10'h005, 1'b1);
    ls(3'h1, 1'b0, 1'b1, 10'h110, 1'b0);
    ls(3'h2, 1'b0, 1'b1, 10'h110, 1'b1);
    ls(3'h2, 1'b1, 1'b1, 10'h13E, 1'b1);
    ls(3'h2, 1'b1, 1'b0, 10'h017, 1'b0);
    ls(3'h3, 1'b0, 1'b0, 10'h064, 1'b0);
    ls(3'h5, 1'b0, 1'b1, 10'h064, 1'b0);
    ls(3'h5, 1'b0, 1'b0, 10'h064, 1'b1);
    wn(8'h02, 8'h05, 8'h00, 12);
    wn(8'h01, 8'h00, 8'h01, 1020);
    rd(8'h44, 8'h05);
    rd(8'h7C, 8'h02);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h48, 8'h7A);
    rd(8'h58, 8'h1F);
    close_out();
  end
endmodule // raw_vbi_capture_window_tb_top
`default_nettype wire
